// ==== include/agsc_pkg.sv ====
// Package for the address generation and stack check block.
// Assumes one 20 MHz core clock and a decoder that presents one request per cycle.
// Behaviour
// - Stack pointer marks next free word, grows upward.
// - Pop decrements first; push increments after write.
// - Call push clears top bit of counter.
// - Exception push merges status low byte high.
// - Stack limit unset at reset, bit zero clear.
// - Stack pointer addresses compared with stack limit.
// - Push at limit passes; next push traps.
// - Stack pointer below 0x0800 raises underflow trap.
// - Boot secure RAM only from boot code.
// - Secure segment RAM only from secure code.
// - File register address is 13 bits wide.
// - File register ops default to working register zero.
// - Post-modify uses pointer; pre-modify adjusts first.
// - Offset modes add register or literal to pointer.
// - Move source and destination share offset field.
// - Prefetch eight, nine to X; ten, eleven to Y.
// - MAC modes: indirect, post-modify by 2/4/6 up or down, indexed.
// - Branch literal signed 16; disable literal 14 unsigned.
package agsc_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam logic [3:0] SP_REG = 4'hf;
   localparam logic [3:0] DEFAULT_WORKING_REG_ZERO = 4'h0;
   localparam logic [3:0] PF_EIGHT = 4'h8;
   localparam logic [3:0] PF_NINE = 4'h9;
   localparam logic [3:0] PF_TEN = 4'ha;
   localparam logic [3:0] PF_ELEVEN = 4'hb;
   localparam logic [15:0] SFR_TOP = 16'h0800;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] SP_RESET = 16'h0800;
   localparam logic [15:0] DEFAULT_WORKING_REG_RESET = 16'h0000;
   localparam int FILE_ADDR_W = 13;

   // Addressing modes of a pointer operand.
   typedef enum logic [2:0] {
      AGSC_DIRECT = 3'h0,
      AGSC_IND = 3'h1,
      AGSC_POST = 3'h3,
      AGSC_PRE = 3'h2,
      AGSC_REG_OFS = 3'h6,
      AGSC_LIT_OFS = 3'h7,
      AGSC_FILE = 3'h5,
      AGSC_LITERAL = 3'h4
   } agsc_mode_t;

   // Instruction classes seen by the address path.
   typedef enum logic [2:0] {
      AGSC_CL_FILE = 3'h0,
      AGSC_CL_MCU = 3'h1,
      AGSC_CL_MOVE = 3'h3,
      AGSC_CL_MAC = 3'h2,
      AGSC_CL_PUSH = 3'h6,
      AGSC_CL_POP = 3'h7,
      AGSC_CL_CALL = 3'h5,
      AGSC_CL_EXC = 3'h4
   } agsc_class_t;

   // Code regions that may be executing.
   typedef enum logic [1:0] {
      AGSC_CODE_GEN = 2'h0,
      AGSC_CODE_SEC = 2'h1,
      AGSC_CODE_BOOT = 2'h3
   } agsc_region_t;

   // One decoded request from the instruction decoder.
   typedef struct packed {
      agsc_class_t cls;
      agsc_mode_t src_mode;
      agsc_mode_t dst_mode;
      logic [3:0] src_reg;
      logic [3:0] dst_reg;
      logic [3:0] ofs_reg;
      logic [15:0] literal;
      logic [15:0] modifier;
      logic byte_op;
      logic to_default_working_reg;
   } agsc_req_t;

   // Address answer for the data memory ports.
   typedef struct packed {
      logic [15:0] src_ea;
      logic [15:0] dst_ea;
      logic src_valid;
      logic dst_valid;
      logic x_space;
      logic [15:0] push_data;
      logic push_en;
   } agsc_addr_t;

   // Trap and refusal flags.
   typedef struct packed {
      logic overflow;
      logic underflow;
      logic secure_fault;
      logic mode_fault;
   } agsc_trap_t;
endpackage

// ==== rtl/agsc_core.sv ====
// Effective address generation, stack pointer tracking and stack checks.
// Assumes the decoder holds each request for one cycle with req_valid_i high.
`timescale 1ns/100ps
module agsc_core (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Decoder request
   input wire logic req_valid_i,
   input wire agsc_pkg::agsc_req_t req_i,
   input wire logic [22:0] pc_i,
   input wire logic [7:0] status_low_byte_i,
   input wire agsc_pkg::agsc_region_t region_i,
   // Working register writes from the execute stage
   input wire logic default_working_reg_we_i,
   input wire logic [3:0] default_working_reg_sel_i,
   input wire logic [15:0] default_working_reg_data_i,
   // Stack limit write
   input wire logic stack_limit_we_i,
   input wire logic [15:0] stack_limit_data_i,
   // Secure RAM windows
   input wire logic boot_secure_ram_en_i,
   input wire logic [15:0] boot_secure_ram_lo_i,
   input wire logic [15:0] boot_secure_ram_hi_i,
   input wire logic secure_segment_ram_en_i,
   input wire logic [15:0] secure_segment_ram_lo_i,
   input wire logic [15:0] secure_segment_ram_hi_i,
   // Branch and disable literals
   input wire logic [15:0] branch_lit_i,
   input wire logic [13:0] disable_lit_i,
   // Results
   output agsc_pkg::agsc_addr_t addr_o,
   output agsc_pkg::agsc_trap_t trap_o,
   output logic [15:0] stack_pointer_reg_o,
   output logic [31:0] branch_disp_o,
   output logic [15:0] disable_count_o
);
   logic [15:0] default_working_reg [0:15];
   logic [15:0] stack_limit_reg;
   logic [15:0] next_src_ea;
   logic [15:0] next_dst_ea;
   logic [15:0] next_src_wb;
   logic [15:0] next_dst_wb;
   logic next_src_wr;
   logic next_dst_wr;
   logic next_src_v;
   logic next_dst_v;
   logic next_mode_bad;
   logic [15:0] next_sp;
   logic [15:0] sp_ea;
   logic sp_used;
   logic push_op;
   logic pop_op;
   logic [15:0] next_push_data;
   logic next_secure_bad;
   logic boot_bad;
   logic seg_bad;
   logic wb_ok;

   // Effective address and pointer writeback for one operand.
   function automatic logic [32:0] ea_calc(input agsc_pkg::agsc_mode_t mode,
                                           input logic [15:0] ptr,
                                           input logic [15:0] ofs,
                                           input logic [15:0] lit,
                                           input logic [15:0] modv);
      logic [15:0] ea;
      logic [15:0] wb;
      logic wr;
      ea = ptr;
      wb = ptr;
      wr = 1'b0;
      case (mode)
         agsc_pkg::AGSC_POST:
         begin
            wb = ptr + modv;
            wr = 1'b1;
         end
         agsc_pkg::AGSC_PRE:
         begin
            ea = ptr + modv;
            wb = ea;
            wr = 1'b1;
         end
         agsc_pkg::AGSC_REG_OFS: ea = ptr + ofs;
         agsc_pkg::AGSC_LIT_OFS: ea = ptr + lit;
         agsc_pkg::AGSC_FILE: ea = {3'h0, lit[agsc_pkg::FILE_ADDR_W-1:0]};
         default: ea = ptr;
      endcase
      ea_calc = {wr, wb, ea};
   endfunction

   // True when an address falls inside the window, both bounds included; the caller checks the enable.
   function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_win = (a >= lo) && (a <= hi);
   endfunction

   // A refused request leaves its pointer registers as they were, except that a push or pop still moves the stack pointer.
   assign wb_ok = req_valid_i && !next_mode_bad && !next_secure_bad;
   assign push_op = req_valid_i && (req_i.cls == agsc_pkg::AGSC_CL_PUSH ||
                                    req_i.cls == agsc_pkg::AGSC_CL_CALL ||
                                    req_i.cls == agsc_pkg::AGSC_CL_EXC);
   assign pop_op = req_valid_i && (req_i.cls == agsc_pkg::AGSC_CL_POP);

   // Address formation for source and destination.
   always_comb
   begin
      logic [32:0] s;
      logic [32:0] d;
      logic [15:0] ofs;
      logic [15:0] lit;
      ofs = default_working_reg[req_i.ofs_reg];
      lit = req_i.literal;
      s = '0;
      d = '0;
      next_src_v = 1'b0;
      next_dst_v = 1'b0;
      next_mode_bad = 1'b0;
      next_sp = default_working_reg[agsc_pkg::SP_REG];
      sp_ea = default_working_reg[agsc_pkg::SP_REG];
      sp_used = 1'b0;
      next_push_data = '0;
      if (req_valid_i)
      begin
         case (req_i.cls)
            agsc_pkg::AGSC_CL_FILE:
            begin
               s = ea_calc(agsc_pkg::AGSC_FILE, 16'h0000, ofs, lit, req_i.modifier);
               d = s;
               next_src_v = 1'b1;
               // result to file register or default working register
               next_dst_v = !req_i.to_default_working_reg;
            end
            // prefetch registers route to X or Y
            agsc_pkg::AGSC_CL_MAC:
            begin
               if (!(req_i.src_mode == agsc_pkg::AGSC_IND ||
                     req_i.src_mode == agsc_pkg::AGSC_REG_OFS ||
                     (req_i.src_mode == agsc_pkg::AGSC_POST &&
                      (req_i.modifier == 16'h0002 || req_i.modifier == 16'h0004 ||
                       req_i.modifier == 16'h0006 || req_i.modifier == 16'hfffe ||
                       req_i.modifier == 16'hfffc || req_i.modifier == 16'hfffa))))
                  next_mode_bad = 1'b1;
               // indexed only with nine or eleven
               if (req_i.src_mode == agsc_pkg::AGSC_REG_OFS &&
                   req_i.src_reg != agsc_pkg::PF_NINE && req_i.src_reg != agsc_pkg::PF_ELEVEN)
                  next_mode_bad = 1'b1;
               if (req_i.src_reg < agsc_pkg::PF_EIGHT || req_i.src_reg > agsc_pkg::PF_ELEVEN)
                  next_mode_bad = 1'b1;
               s = ea_calc(req_i.src_mode, default_working_reg[req_i.src_reg], ofs, lit, req_i.modifier);
               next_src_v = !next_mode_bad;
            end
            agsc_pkg::AGSC_CL_PUSH, agsc_pkg::AGSC_CL_CALL, agsc_pkg::AGSC_CL_EXC:
            begin
               sp_ea = default_working_reg[agsc_pkg::SP_REG];
               sp_used = 1'b1;
               next_sp = sp_ea + agsc_pkg::WORD_STEP;
               d = {17'h0, sp_ea};
               next_dst_v = 1'b1;
               if (req_i.cls == agsc_pkg::AGSC_CL_CALL)
                  next_push_data = {9'h000, pc_i[22:16]};
               else if (req_i.cls == agsc_pkg::AGSC_CL_EXC)
                  next_push_data = {status_low_byte_i, 1'b0, pc_i[22:16]};
               else
                  next_push_data = default_working_reg[req_i.src_reg];
            end
            agsc_pkg::AGSC_CL_POP:
            begin
               sp_ea = default_working_reg[agsc_pkg::SP_REG] - agsc_pkg::WORD_STEP;
               sp_used = 1'b1;
               next_sp = sp_ea;
               s = {17'h0, sp_ea};
               next_src_v = 1'b1;
            end
            // MCU and move share one offset field
            default:
            begin
               s = ea_calc(req_i.src_mode, default_working_reg[req_i.src_reg], ofs, lit, req_i.modifier);
               d = ea_calc(req_i.dst_mode, default_working_reg[req_i.dst_reg], ofs, lit, req_i.modifier);
               next_src_v = req_i.src_mode != agsc_pkg::AGSC_DIRECT &&
                            req_i.src_mode != agsc_pkg::AGSC_LITERAL;
               next_dst_v = req_i.dst_mode != agsc_pkg::AGSC_DIRECT;
               if (req_i.cls == agsc_pkg::AGSC_CL_MCU &&
                   (req_i.dst_mode == agsc_pkg::AGSC_REG_OFS ||
                    req_i.src_mode == agsc_pkg::AGSC_REG_OFS))
                  next_mode_bad = 1'b1;
               if (req_i.src_reg == agsc_pkg::SP_REG && next_src_v)
               begin
                  sp_used = 1'b1;
                  sp_ea = s[15:0];
               end
               else if (req_i.dst_reg == agsc_pkg::SP_REG && next_dst_v)
               begin
                  sp_used = 1'b1;
                  sp_ea = d[15:0];
               end
            end
         endcase
      end
      next_src_ea = s[15:0];
      next_src_wb = s[31:16];
      next_src_wr = s[32];
      next_dst_ea = d[15:0];
      next_dst_wb = d[31:16];
      next_dst_wr = d[32];
   end

   always_comb
   begin
      boot_bad = 1'b0;
      if (boot_secure_ram_en_i && region_i != agsc_pkg::AGSC_CODE_BOOT &&
          ((next_src_v && in_win(next_src_ea, boot_secure_ram_lo_i, boot_secure_ram_hi_i)) ||
           (next_dst_v && in_win(next_dst_ea, boot_secure_ram_lo_i, boot_secure_ram_hi_i))))
         boot_bad = 1'b1;
   end

   always_comb
   begin
      seg_bad = 1'b0;
      if (secure_segment_ram_en_i && region_i != agsc_pkg::AGSC_CODE_SEC &&
          ((next_src_v && in_win(next_src_ea, secure_segment_ram_lo_i,
                                 secure_segment_ram_hi_i)) ||
           (next_dst_v && in_win(next_dst_ea, secure_segment_ram_lo_i,
                                 secure_segment_ram_hi_i))))
         seg_bad = 1'b1;
   end

   assign next_secure_bad = boot_bad || seg_bad;

   // Overflow checks mean nothing until software has loaded the limit once.
   // no reset value, bit zero forced clear
   always_ff @(posedge ref_clk_i)
   begin
      if (stack_limit_we_i)
         stack_limit_reg <= {stack_limit_data_i[15:1], 1'b0};
   end

   // Working registers; the stack pointer also follows stack operations.
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         for (int i = 0; i < 16; i++)
            default_working_reg[i] <= agsc_pkg::DEFAULT_WORKING_REG_RESET;
         default_working_reg[agsc_pkg::SP_REG] <= agsc_pkg::SP_RESET;
      end
      else
      begin
         if (wb_ok && next_src_wr)
            default_working_reg[req_i.src_reg] <= next_src_wb;
         if (wb_ok && next_dst_wr)
            default_working_reg[req_i.dst_reg] <= next_dst_wb;
         // pointer kept on next free word
         if (push_op || pop_op)
            default_working_reg[agsc_pkg::SP_REG] <= {next_sp[15:1], 1'b0};
         // Software writes to the stack pointer keep it word aligned.
         if (default_working_reg_we_i && default_working_reg_sel_i == agsc_pkg::SP_REG)
            default_working_reg[agsc_pkg::SP_REG] <= {default_working_reg_data_i[15:1], 1'b0};
         else if (default_working_reg_we_i)
            default_working_reg[default_working_reg_sel_i] <= default_working_reg_data_i;
      end
   end

   // Registered address answer.
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         addr_o <= '0;
      end
      else
      begin
         addr_o.src_ea <= next_src_ea;
         addr_o.dst_ea <= next_dst_ea;
         addr_o.src_valid <= next_src_v && !next_secure_bad;
         addr_o.dst_valid <= next_dst_v && !next_secure_bad;
         addr_o.x_space <= !(req_i.cls == agsc_pkg::AGSC_CL_MAC &&
                             req_i.src_reg >= agsc_pkg::PF_TEN);
         addr_o.push_data <= next_push_data;
         addr_o.push_en <= push_op && !next_secure_bad;
      end
   end

   // Registered trap flags, each standing for one cycle.
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         trap_o <= '0;
      end
      else
      begin
         trap_o.overflow <= sp_used && (sp_ea > stack_limit_reg);
         trap_o.underflow <= sp_used && (sp_ea < agsc_pkg::SFR_TOP);
         trap_o.secure_fault <= next_secure_bad;
         trap_o.mode_fault <= req_valid_i && next_mode_bad;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         branch_disp_o <= '0;
      end
      else
      begin
         branch_disp_o <= {{16{branch_lit_i[15]}}, branch_lit_i};
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         disable_count_o <= '0;
      end
      else
      begin
         disable_count_o <= {2'h0, disable_lit_i};
      end
   end

   assign stack_pointer_reg_o = default_working_reg[agsc_pkg::SP_REG];
endmodule

// ==== bench/agsc_core_properties.sv ====
// Concurrent checks on the ports of the address and stack block.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/100ps
module agsc_core_properties (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Request side
   input wire logic req_valid_i,
   input wire agsc_pkg::agsc_req_t req_i,
   input wire logic [22:0] pc_i,
   input wire logic [7:0] status_low_byte_i,
   input wire agsc_pkg::agsc_region_t region_i,
   input wire logic stack_limit_we_i,
   input wire logic [15:0] stack_limit_data_i,
   input wire logic boot_secure_ram_en_i,
   input wire logic secure_segment_ram_en_i,
   // Results
   input wire agsc_pkg::agsc_addr_t addr_o,
   input wire agsc_pkg::agsc_trap_t trap_o,
   input wire logic [15:0] stack_pointer_reg_o
);
   logic [15:0] lim;
   logic [6:0] pc_hi;
   logic stk;
   logic pop;
   logic bad_rgn;
   // Classes four to six all push onto the stack.
   assign stk = req_valid_i && req_i.cls[2] && req_i.cls != agsc_pkg::AGSC_CL_POP;
   assign pop = req_valid_i && req_i.cls == agsc_pkg::AGSC_CL_POP;
   assign pc_hi = pc_i[22:16];
   assign bad_rgn = (boot_secure_ram_en_i && region_i != agsc_pkg::AGSC_CODE_BOOT)
      || (secure_segment_ram_en_i && region_i != agsc_pkg::AGSC_CODE_SEC);
   // The limit copy is not reset, like the register it mirrors.
   always_ff @(posedge ref_clk_i)
   begin
      if (stack_limit_we_i)
      begin
         lim <= stack_limit_data_i & 16'hfffe;
      end
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   chk_push_step: assert property (
      stk |=> trap_o.overflow || stack_pointer_reg_o == $past(stack_pointer_reg_o) + 16'h2)
      else $error("push did not advance the stack pointer");
   chk_push_addr: assert property (
      stk |=> addr_o.push_en && addr_o.dst_ea == $past(stack_pointer_reg_o))
      else $error("push address is not the free word");
   chk_pop_step: assert property (
      pop |=> trap_o.underflow || stack_pointer_reg_o == $past(stack_pointer_reg_o) - 16'h2)
      else $error("pop did not lower the stack pointer");
   chk_pop_addr: assert property (
      pop |=> addr_o.src_ea == $past(stack_pointer_reg_o) - 16'h2)
      else $error("pop address not decremented first");
   chk_call_top: assert property (
      req_valid_i && req_i.cls == agsc_pkg::AGSC_CL_CALL
      |=> addr_o.push_data == {9'h0, $past(pc_hi)})
      else $error("call push data wrong");
   chk_exc_status: assert property (
      req_valid_i && req_i.cls == agsc_pkg::AGSC_CL_EXC
      |=> addr_o.push_data == {$past(status_low_byte_i), 1'h0, $past(pc_hi)})
      else $error("exception push data wrong");
   chk_limit_cmp: assert property (
      stk |=> trap_o.overflow == ($past(stack_pointer_reg_o) > $past(lim)))
      else $error("overflow flag disagrees with limit");
   chk_under_trap: assert property (
      pop && stack_pointer_reg_o < 16'h0802 |=> trap_o.underflow)
      else $error("missing underflow trap");
   chk_secure_cause: assert property (
      trap_o.secure_fault |-> $past(bad_rgn) && !addr_o.src_valid && !addr_o.dst_valid)
      else $error("secure fault without cause");
   cover property (stk ##1 trap_o.overflow);
   cover property (pop ##1 trap_o.underflow);
   cover property (trap_o.secure_fault);
   cover property (trap_o.mode_fault);
endmodule
bind agsc_core agsc_core_properties agsc_core_properties_inst (.ref_clk_i, .sys_rst_i,
   .req_valid_i, .req_i, .pc_i, .status_low_byte_i, .region_i, .stack_limit_we_i,
   .stack_limit_data_i, .boot_secure_ram_en_i, .secure_segment_ram_en_i, .addr_o,
   .trap_o, .stack_pointer_reg_o);

// ==== bench/agsc_dec_model.sv ====
// Decoder stand-in that presents one request per cycle to the block.
// Assumes the bench raises send_i for one cycle per request.
`timescale 1ns/100ps
module agsc_dec_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Bench side
   input wire logic send_i,
   input wire agsc_pkg::agsc_req_t cmd_i,
   // Block side
   output logic req_valid_o,
   output agsc_pkg::agsc_req_t req_o
);
   // Each idle cycle inverts the request shown so stale fields are never trusted.
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         req_valid_o <= 1'h0;
         req_o <= '0;
      end
      else
      begin
         req_valid_o <= send_i;
         req_o <= send_i ? cmd_i : ~req_o;
      end
   end
endmodule

// ==== bench/agsc_core_tb.sv ====
// Self-checking bench for the address generation and stack check block.
// Assumes the decoder stand-in adds one cycle ahead of the block.
`timescale 1ns/100ps
module agsc_core_tb;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic send = 1'h0;
   agsc_pkg::agsc_req_t cmd = '0;
   agsc_pkg::agsc_req_t req;
   agsc_pkg::agsc_req_t q;
   logic req_valid;
   logic [22:0] pc = '0;
   logic [7:0] status_low_byte = '0;
   agsc_pkg::agsc_region_t region = agsc_pkg::AGSC_CODE_GEN;
   logic wwe = 1'h0;
   logic [3:0] wsel = '0;
   logic [15:0] wdat = '0;
   logic lwe = 1'h0;
   logic [15:0] ldat = '0;
   logic bs_en = 1'h1;
   logic ss_en = 1'h1;
   logic [15:0] blit = '0;
   logic [13:0] dlit = '0;
   agsc_pkg::agsc_addr_t addr;
   agsc_pkg::agsc_trap_t trap;
   logic [15:0] sp;
   logic [31:0] disp;
   logic [15:0] dcnt;
   int err_total = 0;
   int checks = 0;
   int msp;
   int mlim;
   int w[16];
   int ea;
   int f;
   int md;
   // Digits: class, mode, register, step, fault expected.
   localparam int TBL [15] = '{'h33420, 'h31400, 'h32440, 'h36400, 'h21800, 'h23820,
      'h23840, 'h23860, 'h23881, 'h26801, 'h26900, 'h21a00, 'h22821, 'h37440, 'h16401};
   agsc_dec_model agsc_dec_model_inst (.ref_clk_i(clk), .sys_rst_i(rst), .send_i(send),
      .cmd_i(cmd), .req_valid_o(req_valid), .req_o(req));
   agsc_core agsc_core_inst (.ref_clk_i(clk), .sys_rst_i(rst), .req_valid_i(req_valid),
      .req_i(req), .pc_i(pc), .status_low_byte_i(status_low_byte), .region_i(region),
      .default_working_reg_we_i(wwe), .default_working_reg_sel_i(wsel), .default_working_reg_data_i(wdat), .stack_limit_we_i(lwe),
      .stack_limit_data_i(ldat), .boot_secure_ram_en_i(bs_en),
      .boot_secure_ram_lo_i(16'h1000), .boot_secure_ram_hi_i(16'h10fe),
      .secure_segment_ram_en_i(ss_en), .secure_segment_ram_lo_i(16'h1100),
      .secure_segment_ram_hi_i(16'h11fe), .branch_lit_i(blit), .disable_lit_i(dlit),
      .addr_o(addr), .trap_o(trap), .stack_pointer_reg_o(sp), .branch_disp_o(disp),
      .disable_count_o(dcnt));
   initial forever #25 clk = ~clk;
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   function automatic agsc_pkg::agsc_req_t mk(input int c, input int m, input int r,
      input int mv);
      mk = '0;
      mk.cls = agsc_pkg::agsc_class_t'(c[2:0]);
      mk.src_mode = agsc_pkg::agsc_mode_t'(m[2:0]);
      mk.src_reg = r[3:0];
      mk.ofs_reg = 4'h3;
      mk.modifier = mv[15:0];
      mk.literal = mv[15:0];
   endfunction
   // The answer stands for one cycle after the block takes the request.
   task automatic issue(input agsc_pkg::agsc_req_t r);
      @(posedge clk);
      send <= 1'h1;
      cmd <= r;
      @(posedge clk) send <= 1'h0;
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wr(input int r, input int v);
      @(posedge clk);
      wwe <= 1'h1;
      wsel <= r[3:0];
      wdat <= v[15:0];
      @(posedge clk) wwe <= 1'h0;
      w[r] = v;
   endtask
   task automatic reset_dut;
      @(posedge clk) rst <= 1'h1;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      msp = 'h800;
      @(negedge clk);
   endtask
   task automatic set_lim(input int v);
      @(posedge clk);
      lwe <= 1'h1;
      ldat <= v[15:0];
      @(posedge clk) lwe <= 1'h0;
      mlim = v & 'hfffe;
      // no stack read right after a limit write
      repeat (2) @(posedge clk);
   endtask
   task automatic push_chk(input int c);
      issue(mk(c, 0, 0, 0));
      f = (pc >> 16) & 'h7f;
      if (c == 4) f = f | (status_low_byte << 8);
      if (c != 6) cmp("push data", f, addr.push_data);
      cmp("overflow", msp > mlim, trap.overflow);
      cmp("push addr", msp, addr.dst_ea);
      msp += 2;
      cmp("stack pointer", msp, sp);
   endtask
   initial
   begin
      #2000000;
      err_total++;
      end_sim();
   end
   initial
   begin
      f = $urandom(32'h9b43);
      reset_dut();
      @(posedge clk) blit <= 16'($urandom);
      dlit <= 14'($urandom);
      repeat (2) @(posedge clk);
      @(negedge clk);
      cmp("reset stack pointer", 'h800, sp);
      cmp("branch literal", {{16{blit[15]}}, blit}, disp);
      cmp("disable literal", {18'h0, dlit}, dcnt);
      $display("end of test: reset and literals");
      set_lim(msp + 3);
      for (int i = 0; i < 3; i++) push_chk(6);
      set_lim('hffe);
      for (int i = 0; i < 6; i++)
      begin
         @(posedge clk) pc <= 23'($urandom);
         status_low_byte <= 8'($urandom);
         push_chk(i % 2 ? 4 : 5);
      end
      $display("end of test: pushes and limit");
      for (int i = 0; i < 10; i++)
      begin
         issue(mk(7, 0, 0, 0));
         msp -= 2;
         cmp("pop addr", msp, addr.src_ea);
         cmp("underflow", msp < 'h800, trap.underflow);
         if (msp >= 'h800) cmp("stack pointer", msp, sp);
      end
      $display("end of test: pops and underflow");
      reset_dut();
      wr(2, 'h1000 | ($urandom & 'hfe));
      for (int r = 0; r < 4; r++)
      begin
         for (int k = 2; k < 4; k++)
         begin
            if (k == 3) wr(2, 'h1100 | ($urandom & 'hfe));
            @(posedge clk) region <= agsc_pkg::agsc_region_t'(r[1:0]);
            bs_en <= r != 2;
            issue(mk(3, 1, 2, 0));
            f = k == 2 ? r < 2 : r != 1;
            cmp("secure fault", f, trap.secure_fault);
            cmp("source valid", !f, addr.src_valid);
            if (k == 3) wr(2, 'h1000 | ($urandom & 'hfe));
         end
      end
      $display("end of test: secure windows");
      @(posedge clk) region <= agsc_pkg::AGSC_CODE_GEN;
      // prefetch pointers stay inside their data spaces
      for (int r = 3; r < 12; r++) wr(r, 'h0900 + 32 * r);
      foreach (TBL[i])
      begin
         issue(mk(TBL[i][19:16], TBL[i][15:12], TBL[i][11:8], TBL[i][7:4]));
         md = TBL[i][15:12];
         f = TBL[i][3:0];
         if (md == 2 && !f) w[TBL[i][11:8]] += TBL[i][7:4];
         ea = w[TBL[i][11:8]] + (md == 6 ? w[3] : md == 7 ? TBL[i][7:4] : 0);
         if (md == 3 && !f) w[TBL[i][11:8]] += TBL[i][7:4];
         cmp("mode fault", f, trap.mode_fault);
         if (!f) cmp("source addr", ea, addr.src_ea);
         if (!f && TBL[i][19:16] == 2) cmp("x space", TBL[i][11:8] < 10, addr.x_space);
      end
      q = mk(0, 5, 0, 0);
      q.literal = 16'hffff;
      issue(q);
      cmp("file addr", 'h1fff, addr.src_ea);
      cmp("file dest", 1, addr.dst_valid);
      q.to_default_working_reg = 1'h1;
      issue(q);
      cmp("file dest", 0, addr.dst_valid);
      $display("end of test: addressing modes");
      end_sim();
   end
endmodule
